/* rtl/lbt_pkg.sv */
// constants, types and helpers shared by the loopback and pattern-test block
package lbt_pkg;
   localparam int CLK_HZ = 10_000_000;
   localparam int ERR_FLASH_MS = 500;
   localparam int ERR_WIN_MS = 100;
   localparam int ERR_FLASH_CYC = CLK_HZ / 1000 * ERR_FLASH_MS;
   localparam int ERR_WIN_CYC = CLK_HZ / 1000 * ERR_WIN_MS;
   localparam int ERR_CONT_THRESH = 16;
   localparam int BIT_DIV = 10;
   localparam int FIFO_WIDTH = 1;
   localparam int FIFO_DEPTH = 8;
   localparam int PRBS_LEN = 9;
   localparam int PATTERN_BITS = 511;
   localparam logic [PRBS_LEN-1:0] PRBS_SEED = 9'h1FF;
   localparam logic [3:0] PRBS_SYNC_BITS = 4'h9;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_ERRCNT = 8'h08;
   localparam logic [7:0] REG_BITCNT = 8'h0C;
   localparam int CTRL_CARRIER_FORCE = 0;
   localparam int CTRL_LLB_EN = 1;
   localparam int CTRL_RLB_EN = 2;
   localparam logic [2:0] CTRL_RESET = 3'h7;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
   localparam logic [1:0] CMD_NONE = 2'h0;
   localparam logic [1:0] CMD_LOOP_REQ = 2'h1;
   localparam logic [1:0] CMD_LOOPING = 2'h2;
   localparam logic MARK = 1'b1;

   typedef enum logic [1:0] {LBT_ERR_IDLE, LBT_ERR_FLASH, LBT_ERR_RUN} lbt_err_state_e;

   // x^9 + x^5 + 1 feedback
   function automatic logic lbt_prbs_fb(input logic [PRBS_LEN-1:0] s);
      return s[8] ^ s[4];
   endfunction
endpackage

/* rtl/lbt_stream_if.sv */
// valid/ready bit stream between the block's own modules
`timescale 1ns/1ps
interface lbt_stream_if #(parameter int W = 1);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src(output valid, output data, input ready);
   modport snk(input valid, input data, output ready);
endinterface

/* rtl/lbt_fifo.sv */
// small synchronous fifo with registered full and empty
`timescale 1ns/1ps
module lbt_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 8
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   lbt_stream_if.snk up,
   lbt_stream_if.src down
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp;
   logic [AW-1:0] rp;
   logic [AW:0] cnt;
   logic [AW:0] next_cnt;
   logic room;
   logic empty;
   logic push;
   logic pop;

   // ready comes straight from a flop, so the top's ready pin is registered
   assign push = up.valid & room;
   assign pop = down.ready & ~empty;
   assign up.ready = room;
   assign down.valid = ~empty;
   assign down.data = mem[rp];

   always_comb begin
      next_cnt = cnt;
      if (push && !pop) begin
         next_cnt = cnt + 1'b1;
      end else if (pop && !push) begin
         next_cnt = cnt - 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wp] <= up.data;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wp <= '0;
         rp <= '0;
         cnt <= '0;
         room <= 1'b1;
         empty <= 1'b1;
      end else begin
         if (push) begin
            wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
         end
         if (pop) begin
            rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
         end
         cnt <= next_cnt;
         room <= (next_cnt != (AW + 1)'(DEPTH));
         empty <= (next_cnt == '0);
      end
   end
endmodule

/* rtl/lbt_prbs.sv */
// 511-bit pattern generator and self-synchronising checker
`timescale 1ns/1ps
module lbt_prbs
   import lbt_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic enable_i,
   input wire logic tx_adv_i,
   input wire logic rx_stb_i,
   input wire logic rx_bit_i,
   output logic tx_bit_o,
   output logic bit_stb_o,
   output logic err_stb_o
);
   logic [PRBS_LEN-1:0] gen;
   logic [PRBS_LEN-1:0] chk;
   logic [3:0] fill;

   assign tx_bit_o = lbt_prbs_fb(gen);

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         gen <= PRBS_SEED;
      end else if (!enable_i) begin
         gen <= PRBS_SEED;
      end else if (tx_adv_i) begin
         gen <= {gen[PRBS_LEN-2:0], lbt_prbs_fb(gen)};
      end
   end

   // checker loads from the line itself, so it locks after nine bits
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         chk <= '0;
         fill <= '0;
         bit_stb_o <= 1'b0;
         err_stb_o <= 1'b0;
      end else begin
         bit_stb_o <= 1'b0;
         err_stb_o <= 1'b0;
         if (!enable_i) begin
            fill <= '0;
         end else if (rx_stb_i) begin
            chk <= {chk[PRBS_LEN-2:0], rx_bit_i};
            if (fill != PRBS_SYNC_BITS) begin
               fill <= fill + 1'b1;
            end else begin
               bit_stb_o <= 1'b1;
               err_stb_o <= rx_bit_i != lbt_prbs_fb(chk);
            end
         end
      end
   end
endmodule

/* rtl/lbt_top.sv */
// loopback selection, pattern tester and indicators of the fiber line driver
//
// Behaviour
// - pattern tester runs only with carrier forced on or RTS/I high.
// - terminal-side data is disconnected while the pattern test runs.
// - analog loop starts from its button or, on V.35, the LLB line.
// - analog loop feeds own transmit to own receiver and lights TEST.
// - analog loop sends steady mark to the emitter, nothing external.
// - with no carrier from the peer: DCD off, receive data mark.
// - remote loop from button or V.35 RLB line; peer is told to loop.
// - on peer request, loop received data to transmitter; TEST lit.
// - digital loop button: tell peer, loop locally, TEST on both.
// - error LED flashes at test start, steady or blinking on errors.
// - analog loop asserts DCD unless carrier not forced and RTS/I low.
// - in self-test TEST and DCD stay lit and RD lights.
// - tester sends and checks the 511-bit V.52 pattern.
// - receive data and clear-to-send held low during pattern test.
// - data set ready low while this unit loops data back.
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module lbt_top
   import lbt_pkg::*;
#(
   parameter bit IS_V35 = 1'b1,
   parameter int FLASH_CYC = ERR_FLASH_CYC,
   parameter int WIN_CYC = ERR_WIN_CYC,
   parameter int DIV = BIT_DIV
) (
   input wire logic MCLK_I,
   input wire logic RST_B_I,
   input wire logic [7:0] S_AXI_AWADDR_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   input wire logic [7:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   output logic [31:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   input wire logic LOCAL_ANALOG_LOOP_BUTTON_I,
   input wire logic REMOTE_DIGITAL_LOOP_BUTTON_I,
   input wire logic LOCAL_DIGITAL_LOOP_BUTTON_I,
   input wire logic PATTERN_TEST_BUTTON_I,
   input wire logic DTE_RTS_I,
   input wire logic DTE_LLB_I,
   input wire logic DTE_RLB_I,
   input wire logic DTE_TXD_I,
   input wire logic DTE_TX_VALID_I,
   output logic DTE_TX_READY_O,
   output logic DTE_RXD_O,
   output logic DTE_RX_STB_O,
   output logic DTE_CTS_O,
   output logic DTE_DSR_O,
   output logic DTE_DCD_O,
   output logic LINK_TXD_O,
   output logic LINK_TX_STB_O,
   output logic [1:0] LINK_CMD_O,
   input wire logic LINK_RXD_I,
   input wire logic LINK_RX_STB_I,
   input wire logic LINK_CARRIER_I,
   input wire logic [1:0] LINK_CMD_I,
   output logic LED_TEST_O,
   output logic LED_DCD_O,
   output logic LED_RD_O,
   output logic LED_ERR_O
);
   import lbt_pkg::*;

   lbt_stream_if #(.W(FIFO_WIDTH)) tx_up ();
   lbt_stream_if #(.W(FIFO_WIDTH)) tx_down ();

   logic [2:0] ctrl;
   logic [31:0] err_total;
   logic [31:0] bit_total;
   logic have_aw;
   logic have_w;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_fire;
   logic clr_err;
   logic clr_bit;
   logic [31:0] status;

   logic carrier_ok;
   logic ana_loop;
   logic rem_req;
   logic dig_loop;
   logic self_loop;
   logic pattern_test_button;
   logic pattern_test_button_d;
   logic tick;
   logic [31:0] div_cnt;
   logic last_rx;
   logic src_bit;
   logic rx_stb;
   logic rx_bit;
   logic rx_carrier;
   logic prbs_tx;
   logic prbs_bit_stb;
   logic prbs_err_stb;

   lbt_err_state_e err_state;
   logic [31:0] err_timer;
   logic [31:0] win_errs;

   // ---------------- mode selection ----------------
   assign carrier_ok = ctrl[CTRL_CARRIER_FORCE] | DTE_RTS_I;
   assign ana_loop = LOCAL_ANALOG_LOOP_BUTTON_I | (IS_V35 & ctrl[CTRL_LLB_EN] & DTE_LLB_I);
   assign rem_req = REMOTE_DIGITAL_LOOP_BUTTON_I | (IS_V35 & ctrl[CTRL_RLB_EN] & DTE_RLB_I);
   assign dig_loop = LOCAL_DIGITAL_LOOP_BUTTON_I;
   // analog loop cuts the line, so a digital loop under it would loop nothing
   assign self_loop = ~ana_loop & (dig_loop | (LINK_CMD_I == CMD_LOOP_REQ));
   assign pattern_test_button = PATTERN_TEST_BUTTON_I & carrier_ok;

   // transmit source: loop-back, pattern, else terminal data or idle mark
   always_comb begin
      if (self_loop) begin
         src_bit = last_rx;
      end else if (pattern_test_button) begin
         src_bit = prbs_tx;
      end else if (tx_down.valid) begin
         src_bit = tx_down.data[0];
      end else begin
         src_bit = MARK;
      end
   end

   assign tx_down.ready = tick & ~self_loop & ~pattern_test_button;
   assign tx_up.valid = DTE_TX_VALID_I & ~pattern_test_button;
   assign tx_up.data = DTE_TXD_I;
   assign DTE_TX_READY_O = tx_up.ready;

   assign rx_stb = ana_loop ? tick : LINK_RX_STB_I;
   assign rx_bit = ana_loop ? src_bit : LINK_RXD_I;
   assign rx_carrier = ana_loop ? carrier_ok : LINK_CARRIER_I;

   lbt_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i(MCLK_I),
      .rst_b_i(RST_B_I),
      .up(tx_up),
      .down(tx_down)
   );

   lbt_prbs u_prbs (
      .clk_i(MCLK_I),
      .rst_b_i(RST_B_I),
      .enable_i(pattern_test_button),
      .tx_adv_i(tick & ~self_loop),
      .rx_stb_i(rx_stb),
      .rx_bit_i(rx_bit),
      .tx_bit_o(prbs_tx),
      .bit_stb_o(prbs_bit_stb),
      .err_stb_o(prbs_err_stb)
   );

   // ---------------- bit timing ----------------
   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         div_cnt <= '0;
         tick <= 1'b0;
      end else begin
         tick <= (div_cnt == 32'(DIV - 1));
         div_cnt <= (div_cnt == 32'(DIV - 1)) ? '0 : div_cnt + 32'h1;
      end
   end

   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         last_rx <= MARK;
      end else if (LINK_RX_STB_I) begin
         last_rx <= LINK_RXD_I;
      end
   end

   // ---------------- line side ----------------
   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         LINK_TXD_O <= MARK;
         LINK_TX_STB_O <= 1'b0;
         LINK_CMD_O <= CMD_NONE;
      end else begin
         LINK_TX_STB_O <= tick;
         if (tick) begin
            LINK_TXD_O <= ana_loop ? MARK : src_bit;
         end
         if (dig_loop) begin
            LINK_CMD_O <= CMD_LOOPING;
         end else if (rem_req) begin
            LINK_CMD_O <= CMD_LOOP_REQ;
         end else begin
            LINK_CMD_O <= CMD_NONE;
         end
      end
   end

   // ---------------- terminal side and indicators ----------------
   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         DTE_RXD_O <= MARK;
         DTE_RX_STB_O <= 1'b0;
         DTE_CTS_O <= 1'b0;
         DTE_DSR_O <= 1'b0;
         DTE_DCD_O <= 1'b0;
         LED_TEST_O <= 1'b0;
         LED_DCD_O <= 1'b0;
         LED_RD_O <= 1'b0;
      end else begin
         if (pattern_test_button) begin
            DTE_RXD_O <= 1'b0;
         end else if (!rx_carrier) begin
            DTE_RXD_O <= MARK;
         end else if (rx_stb) begin
            DTE_RXD_O <= rx_bit;
         end
         DTE_RX_STB_O <= rx_stb & rx_carrier & ~pattern_test_button;
         DTE_CTS_O <= ~pattern_test_button;
         DTE_DSR_O <= ~self_loop;
         DTE_DCD_O <= rx_carrier;
         LED_DCD_O <= rx_carrier;
         LED_TEST_O <= ana_loop | self_loop | rem_req | (LINK_CMD_I == CMD_LOOPING);
         LED_RD_O <= pattern_test_button | (rx_stb & ~rx_bit);
      end
   end

   // ---------------- error indicator ----------------
   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         pattern_test_button_d <= 1'b0;
         err_state <= LBT_ERR_IDLE;
         err_timer <= '0;
         win_errs <= '0;
         LED_ERR_O <= 1'b0;
      end else begin
         pattern_test_button_d <= pattern_test_button;
         unique case (err_state)
            LBT_ERR_IDLE: begin
               LED_ERR_O <= 1'b0;
               if (pattern_test_button && !pattern_test_button_d) begin
                  err_state <= LBT_ERR_FLASH;
                  err_timer <= '0;
                  LED_ERR_O <= 1'b1;
               end
            end
            LBT_ERR_FLASH: begin
               err_timer <= err_timer + 32'h1;
               if (!pattern_test_button) begin
                  err_state <= LBT_ERR_IDLE;
               end else if (err_timer == 32'(FLASH_CYC - 1)) begin
                  err_state <= LBT_ERR_RUN;
                  err_timer <= '0;
                  win_errs <= '0;
                  LED_ERR_O <= 1'b0;
               end
            end
            LBT_ERR_RUN: begin
               err_timer <= err_timer + 32'h1;
               win_errs <= win_errs + {31'h0, prbs_err_stb};
               if (!pattern_test_button) begin
                  err_state <= LBT_ERR_IDLE;
               end else if (err_timer == 32'(WIN_CYC - 1)) begin
                  err_timer <= '0;
                  win_errs <= '0;
                  // many errors per window reads as steady, a few as blinking
                  if (win_errs >= 32'(ERR_CONT_THRESH)) begin
                     LED_ERR_O <= 1'b1;
                  end else if (win_errs != '0) begin
                     LED_ERR_O <= ~LED_ERR_O;
                  end else begin
                     LED_ERR_O <= 1'b0;
                  end
               end
            end
         endcase
      end
   end

   // ---------------- register bus ----------------
   assign wr_fire = have_aw & have_w & ~S_AXI_BVALID_O;
   assign clr_err = wr_fire & (aw_addr == REG_ERRCNT) & w_strb[0];
   assign clr_bit = wr_fire & (aw_addr == REG_BITCNT) & w_strb[0];
   assign status = {24'h0, LED_ERR_O, pattern_test_button, self_loop, dig_loop, rem_req, ana_loop, rx_carrier, carrier_ok};

   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         have_aw <= 1'b0;
         have_w <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
         S_AXI_AWREADY_O <= 1'b1;
         S_AXI_WREADY_O <= 1'b1;
         S_AXI_BVALID_O <= 1'b0;
         S_AXI_BRESP_O <= AXI_OKAY;
         ctrl <= CTRL_RESET;
      end else begin
         if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
            have_aw <= 1'b1;
            aw_addr <= S_AXI_AWADDR_I;
            S_AXI_AWREADY_O <= 1'b0;
         end
         if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
            have_w <= 1'b1;
            w_data <= S_AXI_WDATA_I;
            w_strb <= S_AXI_WSTRB_I;
            S_AXI_WREADY_O <= 1'b0;
         end
         if (wr_fire) begin
            S_AXI_BVALID_O <= 1'b1;
            S_AXI_BRESP_O <= AXI_OKAY;
            unique case (aw_addr)
               REG_CTRL: begin
                  if (w_strb[0]) begin
                     ctrl <= w_data[2:0];
                  end
               end
               REG_STATUS, REG_ERRCNT, REG_BITCNT: begin
               end
               default: S_AXI_BRESP_O <= AXI_SLVERR;
            endcase
         end
         if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
            S_AXI_BVALID_O <= 1'b0;
            have_aw <= 1'b0;
            have_w <= 1'b0;
            S_AXI_AWREADY_O <= 1'b1;
            S_AXI_WREADY_O <= 1'b1;
         end
      end
   end

   // counting beats the write that clears, so no event is lost
   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         err_total <= '0;
         bit_total <= '0;
      end else begin
         err_total <= (clr_err ? 32'h0 : err_total) + {31'h0, prbs_err_stb};
         bit_total <= (clr_bit ? 32'h0 : bit_total) + {31'h0, prbs_bit_stb};
      end
   end

   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         S_AXI_ARREADY_O <= 1'b1;
         S_AXI_RVALID_O <= 1'b0;
         S_AXI_RDATA_O <= '0;
         S_AXI_RRESP_O <= AXI_OKAY;
      end else begin
         if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O <= 1'b1;
            S_AXI_RRESP_O <= AXI_OKAY;
            unique case (S_AXI_ARADDR_I)
               REG_CTRL: S_AXI_RDATA_O <= {29'h0, ctrl};
               REG_STATUS: S_AXI_RDATA_O <= status;
               REG_ERRCNT: S_AXI_RDATA_O <= err_total;
               REG_BITCNT: S_AXI_RDATA_O <= bit_total;
               default: begin
                  S_AXI_RDATA_O <= '0;
                  S_AXI_RRESP_O <= AXI_SLVERR;
               end
            endcase
         end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_ARREADY_O <= 1'b1;
         end
      end
   end
endmodule

/* sim/lbt_peer.sv */
// far-side fiber unit: answers loop requests and echoes the line when asked
`timescale 1ns/1ps
module lbt_peer
   import lbt_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic txd_i,
   input wire logic tx_stb_i,
   input wire logic [1:0] cmd_i,
   input wire logic carrier_en_i,
   input wire logic corrupt_i,
   input wire logic req_i,
   output logic rxd_o,
   output logic rx_stb_o,
   output logic carrier_o,
   output logic [1:0] cmd_o
);
   assign carrier_o = carrier_en_i;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rxd_o <= MARK;
         rx_stb_o <= 1'h0;
         cmd_o <= CMD_NONE;
      end else begin
         cmd_o <= req_i ? CMD_LOOP_REQ : (cmd_i == CMD_LOOP_REQ ? CMD_LOOPING : CMD_NONE);
         rx_stb_o <= (cmd_i == CMD_LOOP_REQ) && tx_stb_i;
         // outside a strobe the line keeps moving so stale bits cannot look valid
         rxd_o <= ((cmd_i == CMD_LOOP_REQ) && tx_stb_i) ? (txd_i ^ corrupt_i) : ~rxd_o;
      end
   end
endmodule

/* sim/lbt_top_checker.sv */
// concurrent checks on the ports of the loopback and pattern-test block
`timescale 1ns/1ps
module lbt_top_checker
   import lbt_pkg::*;
(
   input logic MCLK_I,
   input logic RST_B_I,
   input logic S_AXI_ARVALID_I,
   input logic S_AXI_ARREADY_O,
   input logic S_AXI_RVALID_O,
   input logic S_AXI_BVALID_O,
   input logic S_AXI_BREADY_I,
   input logic [1:0] S_AXI_BRESP_O,
   input logic LOCAL_ANALOG_LOOP_BUTTON_I,
   input logic REMOTE_DIGITAL_LOOP_BUTTON_I,
   input logic LOCAL_DIGITAL_LOOP_BUTTON_I,
   input logic PATTERN_TEST_BUTTON_I,
   input logic DTE_RTS_I,
   input logic DTE_LLB_I,
   input logic DTE_RXD_O,
   input logic DTE_RX_STB_O,
   input logic DTE_CTS_O,
   input logic DTE_DSR_O,
   input logic DTE_DCD_O,
   input logic LINK_TXD_O,
   input logic LINK_TX_STB_O,
   input logic [1:0] LINK_CMD_O,
   input logic LINK_CARRIER_I,
   input logic [1:0] LINK_CMD_I,
   input logic LED_TEST_O,
   input logic LED_DCD_O,
   input logic LED_ERR_O
);
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RST_B_I);
   AST_ANA_MARK: assert property ($past(LOCAL_ANALOG_LOOP_BUTTON_I) && LINK_TX_STB_O |-> LINK_TXD_O)
      else $error("emitter not at mark in analog loop");
   AST_ANA_TEST: assert property ($past(LOCAL_ANALOG_LOOP_BUTTON_I) |-> LED_TEST_O)
      else $error("test lamp dark in analog loop");
   AST_ANA_DCD: assert property ($past(LOCAL_ANALOG_LOOP_BUTTON_I && DTE_RTS_I) |-> DTE_DCD_O)
      else $error("carrier detect off in analog loop");
   AST_SELF: assert property ($past(LOCAL_ANALOG_LOOP_BUTTON_I && PATTERN_TEST_BUTTON_I && DTE_RTS_I)
      |-> LED_TEST_O && LED_DCD_O)
      else $error("self-test lamps wrong");
   AST_NO_CARRIER: assert property ($past(!LINK_CARRIER_I && !LOCAL_ANALOG_LOOP_BUTTON_I && !DTE_LLB_I
      && !PATTERN_TEST_BUTTON_I) |-> !DTE_DCD_O && DTE_RXD_O)
      else $error("no carrier but receive active");
   AST_PATTERN_TEST_BUTTON_MUTE: assert property ($past(PATTERN_TEST_BUTTON_I && DTE_RTS_I)
      |-> !DTE_RXD_O && !DTE_CTS_O && !DTE_RX_STB_O)
      else $error("terminal not muted in pattern test");
   AST_DIG_CMD: assert property ($past(LOCAL_DIGITAL_LOOP_BUTTON_I) |-> LINK_CMD_O == CMD_LOOPING)
      else $error("digital loop not signalled");
   AST_REM_CMD: assert property ($past(REMOTE_DIGITAL_LOOP_BUTTON_I && !LOCAL_DIGITAL_LOOP_BUTTON_I)
      |-> LINK_CMD_O == CMD_LOOP_REQ)
      else $error("remote loop not requested");
   AST_DSR: assert property ($past(LINK_CMD_I == CMD_LOOP_REQ && !LOCAL_ANALOG_LOOP_BUTTON_I && !DTE_LLB_I)
      |-> !DTE_DSR_O && LED_TEST_O)
      else $error("data set ready high while looping");
   AST_ERR_FLASH: assert property ($rose(PATTERN_TEST_BUTTON_I) && DTE_RTS_I |=> LED_ERR_O [*8])
      else $error("error lamp did not flash");
   AST_TX_TICK: assert property (LINK_TX_STB_O |=> !LINK_TX_STB_O [*3] ##1 LINK_TX_STB_O)
      else $error("line strobe spacing wrong");
   AST_B_HOLD: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
      else $error("write response dropped");
   AST_R_LAT: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
      else $error("read answer late");
endmodule
bind lbt_top lbt_top_checker u_chk (.*);

/* sim/tb_lbt_top.sv */
// self-checking bench of the loopback and pattern-test block
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_lbt_top;
   import lbt_pkg::*;
   logic MCLK_I = 1'h0, RST_B_I = 1'h0, S_AXI_AWVALID_I = 1'h0, S_AXI_WVALID_I = 1'h0, S_AXI_BREADY_I = 1'h0;
   logic S_AXI_ARVALID_I = 1'h0, S_AXI_RREADY_I = 1'h0, DTE_TXD_I = 1'h0, DTE_TX_VALID_I = 1'h0, DTE_RTS_I = 1'h0;
   logic LOCAL_ANALOG_LOOP_BUTTON_I = 1'h0, REMOTE_DIGITAL_LOOP_BUTTON_I = 1'h0, LOCAL_DIGITAL_LOOP_BUTTON_I = 1'h0;
   logic PATTERN_TEST_BUTTON_I = 1'h0, DTE_LLB_I = 1'h0, DTE_RLB_I = 1'h0, carrier_en = 1'h1, corrupt = 1'h0;
   logic peer_req = 1'h0;
   logic [7:0] S_AXI_AWADDR_I = 8'h00, S_AXI_ARADDR_I = 8'h00;
   logic [31:0] S_AXI_WDATA_I = 32'h0, S_AXI_RDATA_O, rd;
   logic [3:0] S_AXI_WSTRB_I = 4'hF;
   logic S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O, DTE_TX_READY_O;
   logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O, LINK_CMD_O, LINK_CMD_I, rr;
   logic DTE_RXD_O, DTE_RX_STB_O, DTE_CTS_O, DTE_DSR_O, DTE_DCD_O, LINK_TXD_O, LINK_TX_STB_O, LINK_RXD_I;
   logic LINK_RX_STB_I, LINK_CARRIER_I, LED_TEST_O, LED_DCD_O, LED_RD_O, LED_ERR_O;
   int error_cnt = 0, check_count = 0, zero_cnt = 0;
   initial begin
      forever #50 MCLK_I = ~MCLK_I;
   end
   lbt_top #(.FLASH_CYC(20), .WIN_CYC(80), .DIV(4)) dut (.*);
   lbt_peer peer (.clk_i(MCLK_I), .rst_b_i(RST_B_I), .txd_i(LINK_TXD_O), .tx_stb_i(LINK_TX_STB_O),
      .cmd_i(LINK_CMD_O), .carrier_en_i(carrier_en), .corrupt_i(corrupt), .req_i(peer_req),
      .rxd_o(LINK_RXD_I), .rx_stb_o(LINK_RX_STB_I), .carrier_o(LINK_CARRIER_I), .cmd_o(LINK_CMD_I));
   always @(posedge MCLK_I) begin
      if (DTE_RX_STB_O === 1'h1 && DTE_RXD_O === 1'h0) zero_cnt++;
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge MCLK_I);
   endtask
   task automatic bound(input int n);
      if (n >= 200) begin
         error_cnt++;
         $display("[ERR] %0t bus timeout", $time);
         give_verdict();
      end
   endtask
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      S_AXI_AWADDR_I <= a;
      S_AXI_WDATA_I <= d;
      S_AXI_AWVALID_I <= 1'h1;
      S_AXI_WVALID_I <= 1'h1;
      do begin
         @(posedge MCLK_I);
         n++;
         if (S_AXI_AWREADY_O === 1'h1) S_AXI_AWVALID_I <= 1'h0;
         if (S_AXI_WREADY_O === 1'h1) S_AXI_WVALID_I <= 1'h0;
      end while (S_AXI_BVALID_O !== 1'h1 && n < 200);
      bound(n);
      // answer kept waiting one cycle, so the response must stand
      S_AXI_BREADY_I <= 1'h1;
      @(posedge MCLK_I);
      `CHK(S_AXI_BRESP_O, er)
      S_AXI_BREADY_I <= 1'h0;
   endtask
   task automatic axi_read(input logic [7:0] a);
      int n;
      n = 0;
      S_AXI_ARADDR_I <= a;
      S_AXI_ARVALID_I <= 1'h1;
      S_AXI_RREADY_I <= 1'h1;
      do begin
         @(posedge MCLK_I);
         n++;
         if (S_AXI_ARREADY_O === 1'h1) S_AXI_ARVALID_I <= 1'h0;
      end while (S_AXI_RVALID_O !== 1'h1 && n < 200);
      bound(n);
      rd = S_AXI_RDATA_O;
      rr = S_AXI_RRESP_O;
   endtask
   // back-to-back pushes outrun the one-per-tick drain, so the buffer must refuse
   task automatic push_zeros(input int n, output int acc, output logic full);
      acc = 0;
      full = 1'h0;
      DTE_TXD_I <= 1'h0;
      DTE_TX_VALID_I <= 1'h1;
      repeat (n) begin
         @(posedge MCLK_I);
         if (DTE_TX_READY_O === 1'h1) acc++;
         else full = 1'h1;
      end
      DTE_TX_VALID_I <= 1'h0;
   endtask
   initial begin
      int acc;
      logic full;
      tick(16);
      RST_B_I <= 1'h1;
      tick(1);
      axi_read(REG_CTRL);
      `CHK({rr, rd}, {AXI_OKAY, 29'h0, CTRL_RESET})
      axi_read(8'h10);
      `CHK({rr, rd}, {AXI_SLVERR, 32'h0})
      axi_write(8'h10, 32'h0, AXI_SLVERR);
      axi_write(REG_STATUS, 32'hFF, AXI_OKAY);
      axi_write(REG_CTRL, 32'h6, AXI_OKAY);
      PATTERN_TEST_BUTTON_I <= 1'h1;
      tick(3);
      axi_read(REG_STATUS);
      `CHK(rd[6], 1'h0)
      DTE_RTS_I <= 1'h1;
      tick(3);
      axi_read(REG_STATUS);
      `CHK({rd[6], DTE_CTS_O}, 2'h2)
      PATTERN_TEST_BUTTON_I <= 1'h0;
      DTE_RTS_I <= 1'h0;
      $display("test registers done");
      LOCAL_ANALOG_LOOP_BUTTON_I <= 1'h1;
      tick(3);
      `CHK({LED_TEST_O, DTE_DCD_O}, 2'h2)
      DTE_RTS_I <= 1'h1;
      tick(3);
      `CHK(DTE_DCD_O, 1'h1)
      zero_cnt = 0;
      push_zeros(16, acc, full);
      `CHK(full, 1'h1)
      tick(60);
      `CHK(zero_cnt, acc)
      $display("test analog loop done");
      axi_write(REG_CTRL, 32'h1, AXI_OKAY);
      PATTERN_TEST_BUTTON_I <= 1'h1;
      tick(3);
      `CHK(LED_ERR_O, 1'h1)
      tick(250);
      `CHK({LED_TEST_O, LED_DCD_O, LED_RD_O, LED_ERR_O}, 4'hE)
      axi_read(REG_ERRCNT);
      `CHK(rd, 32'h0)
      axi_read(REG_BITCNT);
      `CHK(rd > 32'h28, 1'h1)
      PATTERN_TEST_BUTTON_I <= 1'h0;
      LOCAL_ANALOG_LOOP_BUTTON_I <= 1'h0;
      $display("test self-test done");
      REMOTE_DIGITAL_LOOP_BUTTON_I <= 1'h1;
      corrupt <= 1'h1;
      tick(4);
      `CHK({LINK_CMD_O, LED_TEST_O}, {CMD_LOOP_REQ, 1'h1})
      PATTERN_TEST_BUTTON_I <= 1'h1;
      tick(300);
      `CHK(LED_ERR_O, 1'h1)
      tick(40);
      `CHK(LED_ERR_O, 1'h1)
      axi_read(REG_ERRCNT);
      `CHK(rd > 32'h10, 1'h1)
      PATTERN_TEST_BUTTON_I <= 1'h0;
      corrupt <= 1'h0;
      axi_write(REG_ERRCNT, 32'h0, AXI_OKAY);
      axi_read(REG_ERRCNT);
      `CHK(rd, 32'h0)
      LOCAL_DIGITAL_LOOP_BUTTON_I <= 1'h1;
      tick(3);
      `CHK({LINK_CMD_O, DTE_DSR_O, LED_TEST_O}, {CMD_LOOPING, 2'h1})
      LOCAL_DIGITAL_LOOP_BUTTON_I <= 1'h0;
      REMOTE_DIGITAL_LOOP_BUTTON_I <= 1'h0;
      peer_req <= 1'h1;
      tick(4);
      `CHK({DTE_DSR_O, LED_TEST_O}, 2'h1)
      peer_req <= 1'h0;
      carrier_en <= 1'h0;
      tick(4);
      `CHK({DTE_DCD_O, DTE_RXD_O}, 2'h1)
      carrier_en <= 1'h1;
      $display("test remote and digital loops done");
      axi_write(REG_CTRL, 32'h6, AXI_OKAY);
      DTE_LLB_I <= 1'h1;
      tick(3);
      `CHK(LED_TEST_O, 1'h1)
      axi_write(REG_CTRL, 32'h1, AXI_OKAY);
      tick(3);
      `CHK(LED_TEST_O, 1'h0)
      DTE_LLB_I <= 1'h0;
      DTE_RLB_I <= 1'h1;
      axi_write(REG_CTRL, 32'h4, AXI_OKAY);
      tick(3);
      `CHK(LINK_CMD_O, CMD_LOOP_REQ)
      $display("test terminal loop lines done");
      give_verdict();
   end
endmodule
